/* File: core/fast_ethernet_mac_pcs.sv */
`timescale 1ns/1ps
`default_nettype none
// How it works
// RULE1: receive checks preamble nibbles then start-of-frame nibble before data
// RULE2: length/type above 05dc hex is reported as a type
// RULE3: short transmit frames flagged unless padding is disabled
// RULE4: received frame check sequence verified by crc-32 residue
// RULE5: first two preamble nibbles replaced by /J/K/
// RULE6: /T/R/ follows the last transmitted nibble
// RULE7: carrier without /J/K/ is dropped until idle returns
// RULE8: missing /T/R/ ends the frame with a crc error
// RULE9: carrier during the 64-bit gap phase restarts it
// RULE10: after the 32-bit phase transmit is permitted regardless of carrier
// RULE11: back-off draws 0 to 2^min(n,10)-1 slot times
// RULE12: transmit nibble sampled on each nibble strobe and 4B/5B encoded
// RULE13: idle code groups sent whenever no frame is active
// RULE14: every code group scrambled, seeded at reset
// RULE15: symbols serialised, NRZ to NRZI, then MLT3
// RULE16: receive NRZI to NRZ, descramble, pack and decode to nibbles
// RULE17: carrier on two non-adjacent zeros in ten bits, off at /T/ or idle
// RULE18: half duplex carrier covers transmit too, full duplex receive only
// RULE19: loop-back keeps idle MLT3 on the line
// RULE20: 100 Mbit/s loop-back feeds transmit NRZI into receive NRZI decoder
// RULE21: 10 Mbit/s loop-back feeds Manchester output to receive recovery
// RULE22: 10 Mbit/s gives collision, SQE test, Manchester, link test, jabber
// RULE23: full duplex ignores collision so no back-off happens
// RULE24: eleven-stage scrambler, descrambler locks on idle first
// RULE25: sixteen failed attempts abandon the frame with an error
module fast_ethernet_mac_pcs #(
   parameter int JABBER_LIMIT = fe_pkg::JABBER_CYC,
   parameter int LINK_PERIOD  = fe_pkg::LINK_CYC
) (
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire fe_pkg::mii_nib_t tx,
   input  wire logic             pad_disable,
   input  wire logic             full_duplex,
   input  wire logic             loopback,
   input  wire logic             speed10,
   input  wire logic             rx_line_nrzi,
   input  wire logic             rx_line_man,
   output logic                  nibble_stb,
   output fe_pkg::mlt3_t         line,
   output logic                  man_line,
   output fe_pkg::mii_nib_t      rx,
   output fe_pkg::rx_stat_t      rx_stat,
   output logic                  crs,
   output logic                  col,
   output logic                  tx_permit,
   output logic                  excess_col,
   output logic                  tx_short,
   output logic                  jabber
);
   typedef enum logic [1:0] {TX_IDLE, TX_K, TX_DATA, TX_R} tx_st_t;
   typedef enum logic [2:0] {RX_IDLE, RX_SEEK, RX_DATA, RX_END, RX_WAIT} rx_st_t;
   typedef enum logic [2:0] {M_DEFER1, M_DEFER2, M_READY, M_TX, M_BACKOFF} mac_st_t;

   tx_st_t      tx_st;
   rx_st_t      rx_st;
   mac_st_t     mac_st;
   logic [2:0]  sym_cnt;
   logic [4:0]  tx_sh;
   logic [11:0] tx_nib;
   logic [10:0] scr;
   logic        loop_nrzi;
   logic        loop_q;
   logic [1:0]  mlt_ph;
   logic [2:0]  nrzi_q;
   logic [2:0]  man_q;
   logic        nrzi_pin;
   logic        man_pin;
   logic        rx_prev;
   logic [10:0] dscr;
   logic        locked;
   logic [6:0]  lock_cnt;
   logic [9:0]  win;
   logic [3:0]  seek_cnt;
   logic [2:0]  rx_bc;
   logic        crs_rx;
   logic        sfd_seen;
   logic        bad;
   logic [31:0] crc;
   logic [11:0] nib_cnt;
   logic [15:0] lt;
   logic        half;
   logic        man_prev;
   logic [7:0]  act10;
   logic [6:0]  sqe_cnt;
   logic [31:0] jab_cnt;
   logic [31:0] link_cnt;
   logic [9:0]  dcnt;
   logic [9:0]  slots;
   logic [4:0]  attempts;
   logic        collided;

   logic        sym_stb;
   logic        tx_act;
   logic        tx_bit;
   logic        key;
   logic        scr_data;
   logic        scr_line;
   logic [1:0]  next_mlt_ph;
   logic        rx_nrzi;
   logic        nrz;
   logic        dkey;
   logic        plain;
   logic        carrier;
   logic [4:0]  sym;
   logic        sym_ok;
   logic [3:0]  sym_nib;
   logic        man_in;
   logic        act_any;
   logic        col_now;

   function automatic logic two_apart(input logic [9:0] w);
      logic f;
      f = 1'b0;
      for (int i = 0; i < 8; i++)
         for (int j = i + 2; j < 10; j++)
            if (!w[i] && !w[j])
               f = 1'b1;
      return f;
   endfunction : two_apart

   function automatic logic [31:0] crc_nib(input logic [31:0] c, input logic [3:0] d);
      logic [31:0] r;
      r = c;
      for (int i = 0; i < 4; i++)
         r = (r >> 1) ^ ((r[0] ^ d[i]) ? fe_pkg::CRC_POLY : 32'h0);
      return r;
   endfunction : crc_nib

   // ---- transmit code groups
   assign sym_stb = (sym_cnt == fe_pkg::SYM_LAST);
   assign tx_act  = (tx_st != TX_IDLE);
   assign tx_bit  = tx_sh[4];

   always_ff @(posedge clk)
      if (rst || sym_stb)
         sym_cnt <= 3'h0;
      else
         sym_cnt <= sym_cnt + 3'h1;

   always_ff @(posedge clk)
      nibble_stb <= !rst && (sym_cnt == fe_pkg::SYM_LAST - 3'h1);

   always_ff @(posedge clk)
   begin
      tx_short <= 1'b0;
      if (rst)
      begin
         tx_st  <= TX_IDLE;
         tx_sh  <= fe_pkg::SYM_I;
         tx_nib <= 12'h0;
      end
      else if (sym_stb)
         unique case (tx_st)
            TX_IDLE:
               if (tx.en && !jabber)
               begin
                  tx_sh  <= fe_pkg::SYM_J; // see RULE5
                  tx_st  <= TX_K;
                  tx_nib <= 12'h0;
               end
               else
                  tx_sh <= fe_pkg::SYM_I; // see RULE13
            TX_K:
            begin
               tx_sh <= fe_pkg::SYM_K; // see RULE5
               tx_st <= TX_DATA;
            end
            TX_DATA:
               if (tx.en && !jabber)
               begin
                  tx_sh  <= fe_pkg::ENC_TAB[tx.data]; // see RULE12
                  tx_nib <= tx_nib + 12'h1;
               end
               else
               begin
                  tx_sh    <= fe_pkg::SYM_T; // see RULE6
                  tx_st    <= TX_R;
                  tx_short <= !pad_disable && (tx_nib < fe_pkg::TX_MIN_NIB); // see RULE3
               end
            TX_R:
            begin
               tx_sh <= fe_pkg::SYM_R; // see RULE6
               tx_st <= TX_IDLE;
            end
         endcase
      else
         tx_sh <= {tx_sh[3:0], 1'b0};
   end

   // ---- scrambler, NRZI and MLT3
   // the loop-back copy uses the same key so the local receiver sees real data
   assign key      = scr[10] ^ scr[8];
   assign scr_data = tx_bit ^ key; // see RULE14
   assign scr_line = (loopback ? 1'b1 : tx_bit) ^ key; // see RULE19
   assign next_mlt_ph = mlt_ph + {1'b0, scr_line};

   always_ff @(posedge clk)
      if (rst)
         scr <= fe_pkg::SCR_SEED; // see RULE24
      else
         scr <= {scr[9:0], key};

   always_ff @(posedge clk)
      if (rst)
      begin
         loop_nrzi <= 1'b0;
         mlt_ph    <= 2'h0;
         line      <= '0;
      end
      else
      begin
         loop_nrzi <= loop_nrzi ^ scr_data; // see RULE15
         mlt_ph    <= next_mlt_ph;
         line.pos  <= !speed10 && (next_mlt_ph == 2'h1); // see RULE15
         line.neg  <= !speed10 && (next_mlt_ph == 2'h3);
      end

   // ---- pin synchronisers
   always_ff @(posedge clk)
      if (rst)
      begin
         nrzi_q   <= 3'h0;
         man_q    <= 3'h0;
         nrzi_pin <= 1'b0;
         man_pin  <= 1'b0;
      end
      else
      begin
         nrzi_q <= {nrzi_q[1:0], rx_line_nrzi};
         man_q  <= {man_q[1:0], rx_line_man};
         // line bits may change every clock, so no agreement wait here
         nrzi_pin <= nrzi_q[2];
         if (man_q[1] == man_q[2])
            man_pin <= man_q[2];
      end

   // ---- receive NRZI, descrambler, window
   assign rx_nrzi = loopback ? loop_nrzi : nrzi_pin; // see RULE20
   assign nrz     = rx_nrzi ^ rx_prev; // see RULE16
   assign dkey    = dscr[10] ^ dscr[8];
   assign plain   = nrz ^ dkey;
   assign carrier = two_apart(win); // see RULE17

   always_ff @(posedge clk)
      loop_q <= loopback;

   // before lock, idle plaintext is all ones, so the key is the inverted cipher
   always_ff @(posedge clk)
      if (rst)
      begin
         rx_prev  <= 1'b0;
         dscr     <= 11'h0;
         locked   <= 1'b0;
         lock_cnt <= 7'h0;
         win      <= fe_pkg::WIN_IDLE;
      end
      else
      begin
         rx_prev <= rx_nrzi;
         dscr    <= {dscr[9:0], locked ? dkey : !nrz}; // see RULE24
         if (loopback != loop_q)
         begin
            // the two receive paths differ in latency, so lock again
            locked   <= 1'b0;
            lock_cnt <= 7'h0;
         end
         else if (!locked)
         begin
            lock_cnt <= (dkey == !nrz) ? lock_cnt + 7'h1 : 7'h0;
            locked   <= (lock_cnt == fe_pkg::LOCK_BITS - 7'h1);
         end
         else
            win <= {win[8:0], plain};
      end

   // ---- receive framing
   assign sym = win[4:0];

   always_comb
   begin
      sym_ok  = 1'b0;
      sym_nib = 4'h0;
      for (int i = 0; i < 16; i++)
         if (fe_pkg::ENC_TAB[i] == sym)
         begin
            sym_ok  = 1'b1;
            sym_nib = 4'(i); // see RULE16
         end
   end

   always_ff @(posedge clk)
   begin
      rx_stat.done <= 1'b0;
      if (rst)
      begin
         rx_st    <= RX_IDLE;
         crs_rx   <= 1'b0;
         seek_cnt <= 4'h0;
         rx_bc    <= 3'h0;
         sfd_seen <= 1'b0;
         bad      <= 1'b0;
         crc      <= fe_pkg::CRC_INIT;
         nib_cnt  <= 12'h0;
         lt       <= 16'h0;
         rx       <= '0;
         rx_stat  <= '0;
      end
      else if (locked)
      begin
         rx_bc <= (rx_bc == fe_pkg::SYM_BITS) ? 3'h1 : rx_bc + 3'h1;
         unique case (rx_st)
            RX_IDLE:
               if (carrier)
               begin
                  crs_rx   <= 1'b1; // see RULE17
                  rx_st    <= RX_SEEK;
                  seek_cnt <= 4'h0;
               end
            RX_SEEK:
               if (win == fe_pkg::SYM_JK)
               begin
                  rx_st    <= RX_DATA;
                  rx_bc    <= 3'h1;
                  sfd_seen <= 1'b0;
                  bad      <= 1'b0;
                  crc      <= fe_pkg::CRC_INIT;
                  nib_cnt  <= 12'h0;
               end
               else if (seek_cnt == fe_pkg::SEEK_BITS - 4'h1)
                  rx_st <= RX_WAIT; // see RULE7
               else
                  seek_cnt <= seek_cnt + 4'h1;
            RX_DATA:
               if (rx_bc == fe_pkg::SYM_BITS)
               begin
                  if (sym_ok && !sfd_seen)
                  begin
                     sfd_seen <= (sym_nib == fe_pkg::NIB_SFD);
                     if (sym_nib != fe_pkg::NIB_SFD && sym_nib != fe_pkg::NIB_PRE)
                        bad <= 1'b1; // see RULE1
                  end
                  else if (sym_ok)
                  begin
                     rx.en   <= 1'b1;
                     rx.data <= sym_nib;
                     crc     <= crc_nib(crc, sym_nib); // see RULE4
                     nib_cnt <= nib_cnt + 12'h1;
                     unique case (nib_cnt)
                        fe_pkg::LT_NIB:          lt[11:8]  <= sym_nib;
                        fe_pkg::LT_NIB + 12'h1:  lt[15:12] <= sym_nib;
                        fe_pkg::LT_NIB + 12'h2:  lt[3:0]   <= sym_nib;
                        fe_pkg::LT_NIB + 12'h3:  lt[7:4]   <= sym_nib;
                        default:                 lt        <= lt;
                     endcase
                  end
                  else if (sym == fe_pkg::SYM_T)
                  begin
                     rx_st  <= RX_END;
                     crs_rx <= 1'b0; // see RULE17
                  end
                  else
                  begin
                     // idle or junk where the end pair should be
                     rx_st           <= RX_WAIT;
                     rx.en           <= 1'b0;
                     rx_stat.done    <= 1'b1;
                     rx_stat.crc_err <= 1'b1; // see RULE8
                     rx_stat.pre_err <= bad || !sfd_seen;
                     rx_stat.is_type <= (lt > fe_pkg::LEN_MAX);
                     rx_stat.runt    <= (nib_cnt < fe_pkg::MIN_NIB);
                     rx_stat.oversize <= (nib_cnt > fe_pkg::MAX_NIB);
                  end
               end
            RX_END:
               if (rx_bc == fe_pkg::SYM_BITS)
               begin
                  rx_st           <= RX_WAIT;
                  rx.en           <= 1'b0;
                  rx_stat.done    <= 1'b1;
                  rx_stat.crc_err <= (sym != fe_pkg::SYM_R) ||
                                     (crc != fe_pkg::CRC_RESIDUE); // see RULE8
                  rx_stat.pre_err <= bad || !sfd_seen; // see RULE1
                  rx_stat.is_type <= (lt > fe_pkg::LEN_MAX); // see RULE2
                  rx_stat.runt    <= (nib_cnt < fe_pkg::MIN_NIB);
                  rx_stat.oversize <= (nib_cnt > fe_pkg::MAX_NIB);
               end
            RX_WAIT:
               // the end pair itself holds zeros, so rearm only on clean idle
               if (win == fe_pkg::WIN_IDLE)
               begin
                  rx_st  <= RX_IDLE;
                  crs_rx <= 1'b0; // see RULE17
               end
         endcase
      end
   end

   // ---- 10 Mbit/s: Manchester, link test, jabber, SQE
   assign man_in  = loopback ? man_line : man_pin; // see RULE21
   assign act_any = speed10 ? (act10 != 8'h0) : crs_rx;

   always_ff @(posedge clk)
      if (rst)
      begin
         half     <= 1'b0;
         man_prev <= 1'b0;
         act10    <= 8'h0;
         man_line <= 1'b0;
         link_cnt <= 32'h0;
      end
      else
      begin
         half     <= !half;
         man_prev <= man_in;
         if (man_in != man_prev)
            act10 <= fe_pkg::ACT10_HOLD;
         else if (act10 != 8'h0)
            act10 <= act10 - 8'h1;
         if (tx_act || !speed10 || link_cnt == 32'(LINK_PERIOD - 1))
            link_cnt <= 32'h0;
         else
            link_cnt <= link_cnt + 32'h1;
         man_line <= speed10 && (tx_act ? (tx_bit ^ half) :
                     (link_cnt == 32'(LINK_PERIOD - 1))); // see RULE22
      end

   always_ff @(posedge clk)
      if (rst || !tx.en)
      begin
         jab_cnt <= 32'h0;
         jabber  <= 1'b0;
      end
      else if (speed10 && tx_act)
      begin
         if (jab_cnt == 32'(JABBER_LIMIT - 1))
            jabber <= 1'b1; // see RULE22
         else
            jab_cnt <= jab_cnt + 32'h1;
      end

   // SQE test pulse a short while after each half-duplex 10 Mbit/s transmission
   always_ff @(posedge clk)
      if (rst)
         sqe_cnt <= 7'h0;
      else if (speed10 && !full_duplex && tx_st == TX_R && sym_stb)
         sqe_cnt <= fe_pkg::SQE_DLY + fe_pkg::SQE_LEN; // see RULE22
      else if (sqe_cnt != 7'h0)
         sqe_cnt <= sqe_cnt - 7'h1;

   // ---- carrier sense and collision
   assign col_now = !full_duplex && !loopback && tx_act && act_any; // see RULE23

   always_ff @(posedge clk)
      if (rst)
      begin
         crs <= 1'b0;
         col <= 1'b0;
      end
      else
      begin
         crs <= act_any || (tx_act && !full_duplex); // see RULE18
         col <= col_now || (sqe_cnt != 7'h0 && sqe_cnt <= fe_pkg::SQE_LEN); // see RULE22
      end

   // ---- deferral and back-off
   always_ff @(posedge clk)
   begin
      excess_col <= 1'b0;
      if (rst)
      begin
         mac_st    <= M_DEFER1;
         dcnt      <= 10'h0;
         slots     <= 10'h0;
         attempts  <= 5'h0;
         collided  <= 1'b0;
         tx_permit <= 1'b0;
      end
      else
      begin
         tx_permit <= (mac_st == M_READY);
         unique case (mac_st)
            M_DEFER1:
               if (act_any || tx_act)
                  dcnt <= 10'h0; // see RULE9
               else if (dcnt == fe_pkg::FIRST_DEFERRAL_PHASE_BITS - 10'h1)
               begin
                  dcnt   <= 10'h0;
                  mac_st <= M_DEFER2;
               end
               else
                  dcnt <= dcnt + 10'h1;
            M_DEFER2:
               if (dcnt == fe_pkg::SECOND_DEFERRAL_PHASE_BITS - 10'h1)
                  mac_st <= M_READY; // see RULE10
               else
                  dcnt <= dcnt + 10'h1;
            M_READY:
               if (tx_act)
               begin
                  mac_st   <= M_TX;
                  collided <= 1'b0;
               end
            M_TX:
               if (col_now)
                  collided <= 1'b1;
               else if (!tx_act)
               begin
                  dcnt <= 10'h0;
                  if (!collided)
                  begin
                     attempts <= 5'h0;
                     mac_st   <= M_DEFER1;
                  end
                  else if (attempts == fe_pkg::ATTEMPT_MAX - 5'h1)
                  begin
                     attempts   <= 5'h0;
                     excess_col <= 1'b1; // see RULE25
                     mac_st     <= M_DEFER1;
                  end
                  else
                  begin
                     attempts <= attempts + 5'h1;
                     // scrambler state doubles as the random source
                     slots    <= scr[9:0] & 10'((11'h1 << ((attempts < fe_pkg::BACKOFF_K_MAX)
                                 ? attempts + 5'h1 : fe_pkg::BACKOFF_K_MAX)) - 11'h1); // see RULE11
                     mac_st   <= M_BACKOFF;
                  end
               end
            M_BACKOFF:
               if (slots == 10'h0)
                  mac_st <= M_DEFER1;
               else if (dcnt == fe_pkg::SLOT_BITS - 10'h1)
               begin
                  dcnt  <= 10'h0;
                  slots <= slots - 10'h1; // see RULE11
               end
               else
                  dcnt <= dcnt + 10'h1;
            default:
               mac_st <= M_DEFER1;
         endcase
      end
   end
endmodule : fast_ethernet_mac_pcs
`default_nettype wire

/* File: core/fe_pkg.sv */
package fe_pkg;
   // line code groups, first transmitted bit in the msb
   localparam logic [4:0] SYM_J = 5'h18;
   localparam logic [4:0] SYM_K = 5'h11;
   localparam logic [4:0] SYM_T = 5'h0d;
   localparam logic [4:0] SYM_R = 5'h07;
   localparam logic [4:0] SYM_I = 5'h1f;
   localparam logic [9:0] SYM_JK = {SYM_J, SYM_K};
   localparam logic [9:0] WIN_IDLE = 10'h3ff;
   localparam logic [4:0] ENC_TAB [16] = '{5'h1e, 5'h09, 5'h14, 5'h15, 5'h0a, 5'h0b,
      5'h0e, 5'h0f, 5'h12, 5'h13, 5'h16, 5'h17, 5'h1a, 5'h1b, 5'h1c, 5'h1d};
   localparam logic [2:0] SYM_BITS = 3'h5;
   localparam logic [2:0] SYM_LAST = 3'h4;

   // frame layout, in nibbles
   localparam logic [3:0]  NIB_PRE = 4'h5;
   localparam logic [3:0]  NIB_SFD = 4'hd;
   localparam logic [11:0] PRE_NIB = 12'h010;
   localparam logic [11:0] MIN_NIB = 12'h080;
   localparam logic [11:0] MAX_NIB = 12'hbdc;
   localparam logic [11:0] TX_MIN_NIB = PRE_NIB - 12'h002 + MIN_NIB;
   localparam logic [11:0] LT_NIB = 12'h018;
   localparam logic [15:0] LEN_MAX = 16'h05dc;
   localparam logic [31:0] CRC_INIT = 32'hffffffff;
   localparam logic [31:0] CRC_POLY = 32'hedb88320;
   localparam logic [31:0] CRC_RESIDUE = 32'hdebb20e3;

   // scrambler and receive alignment
   localparam logic [10:0] SCR_SEED = 11'h0ff;
   localparam logic [6:0]  LOCK_BITS = 7'h40;
   localparam logic [3:0]  SEEK_BITS = 4'ha;

   // access timing, one bit time per clock
   localparam logic [9:0] FIRST_DEFERRAL_PHASE_BITS = 10'h040;
   localparam logic [9:0] SECOND_DEFERRAL_PHASE_BITS = 10'h020;
   localparam logic [9:0] SLOT_BITS = 10'h200;
   localparam logic [4:0] ATTEMPT_MAX = 5'h10;
   localparam logic [4:0] BACKOFF_K_MAX = 5'h0a;

   // 10 Mbit/s side
   localparam int CLK_NS = 20;
   localparam int SQE_DLY_NS = 1000;
   localparam int SQE_LEN_NS = 1000;
   localparam logic [6:0] SQE_DLY = 7'((SQE_DLY_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [6:0] SQE_LEN = 7'(SQE_LEN_NS / CLK_NS);
   localparam int JABBER_MS = 20;
   localparam int LINK_MS = 16;
   localparam int JABBER_CYC = JABBER_MS * 1000000 / CLK_NS;
   localparam int LINK_CYC = LINK_MS * 1000000 / CLK_NS;
   localparam logic [7:0] ACT10_HOLD = 8'hff;

   typedef struct packed {
      logic       en;
      logic [3:0] data;
   } mii_nib_t;

   typedef struct packed {
      logic pos;
      logic neg;
   } mlt3_t;

   typedef struct packed {
      logic done;
      logic crc_err;
      logic pre_err;
      logic is_type;
      logic runt;
      logic oversize;
   } rx_stat_t;
endpackage : fe_pkg

/* File: sim/fe_mac_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module fe_mac_properties (
   input wire logic             clk,
   input wire logic             rst,
   input wire logic             full_duplex,
   input wire logic             loopback,
   input wire logic             pad_disable,
   input wire logic             nibble_stb,
   input wire fe_pkg::mlt3_t    line,
   input wire fe_pkg::rx_stat_t rx_stat,
   input wire logic             col,
   input wire logic             tx_short,
   input wire logic             excess_col
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   a_stb_period: assert property (nibble_stb |=> !nibble_stb [*4] ##1 nibble_stb)
      else $error("strobe spacing");
   a_mlt3_legal: assert property (!(line.pos && line.neg))
      else $error("mlt3 level");
   a_fd_no_col: assert property (full_duplex && $past(full_duplex) |-> !col)
      else $error("col in full duplex");
   a_loop_no_col: assert property (loopback && $past(loopback) |-> !col)
      else $error("col in loop-back");
   a_done_pulse: assert property (rx_stat.done |=> !rx_stat.done)
      else $error("done width");
   a_stat_held: assert property (!rx_stat.done |=> rx_stat.done || $stable(rx_stat))
      else $error("status moved");
   a_excess_pulse: assert property (excess_col |=> !excess_col)
      else $error("excess width");
   a_pad_short: assert property (pad_disable && $past(pad_disable) |-> !tx_short)
      else $error("short with pad off");
endmodule : fe_mac_properties
bind fast_ethernet_mac_pcs fe_mac_properties props (.clk, .rst, .full_duplex, .loopback,
   .pad_disable, .nibble_stb, .line, .rx_stat, .col, .tx_short, .excess_col);
`default_nettype wire

/* File: sim/fe_link_partner.sv */
`timescale 1ns/1ps
`default_nettype none
module fe_link_partner (
   input  wire logic          clk,
   input  wire logic          rst,
   input  wire fe_pkg::mlt3_t line,
   output logic               rx_line_nrzi
);
   fe_pkg::mlt3_t last;
   // far end reflects our own signal, so a collision needs no second talker
   always_ff @(negedge clk)
   begin
      last <= line;
      if (rst)
         rx_line_nrzi <= 1'b0;
      else if (line != last)
         rx_line_nrzi <= ~rx_line_nrzi;
   end
endmodule : fe_link_partner
`default_nettype wire

/* File: sim/fast_ethernet_mac_pcs_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module fast_ethernet_mac_pcs_bench;
   logic             clk, rst, pad_disable, full_duplex, loopback, speed10;
   logic             rx_line_nrzi, rx_line_man, nibble_stb, man_line;
   logic             crs, col, tx_permit, excess_col, tx_short, jabber;
   fe_pkg::mii_nib_t tx, rx;
   fe_pkg::mlt3_t    line;
   fe_pkg::rx_stat_t rx_stat, stat;
   int               num_errors, checks, n_short, n_col, n_crs, n_rx, n_done, cyc, crs_at, n_man;
   logic [3:0]       rx_last;

   fast_ethernet_mac_pcs #(.JABBER_LIMIT(200), .LINK_PERIOD(300)) DUT (
      .clk, .rst, .tx, .pad_disable, .full_duplex, .loopback, .speed10, .rx_line_nrzi,
      .rx_line_man, .nibble_stb, .line, .man_line, .rx, .rx_stat, .crs, .col, .tx_permit,
      .excess_col, .tx_short, .jabber);
   fe_link_partner far_end (.clk, .rst, .line, .rx_line_nrzi);

   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   always @(posedge clk)
   begin
      cyc++;
      n_short += tx_short;
      n_col += col;
      n_crs += crs;
      n_rx += rx.en;
      n_man += man_line;
      if (rx.en)
         rx_last = rx.data;
      if (crs)
         crs_at = cyc;
      if (rx_stat.done)
      begin
         n_done++;
         stat = rx_stat;
      end
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task automatic final_report;
      $display("checks=%0d mismatches=%0d", checks, num_errors);
      if (num_errors == 0 && checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : final_report

   task automatic wait_stb;
      int n;
      n = 0;
      @(negedge clk);
      while (nibble_stb !== 1'b1 && n < 10)
      begin
         @(negedge clk);
         n++;
      end
   endtask : wait_stb

   task automatic wait_permit(output int n);
      n = 0;
      while (tx_permit !== 1'b1 && n < 2000)
      begin
         @(negedge clk);
         n++;
      end
   endtask : wait_permit

   // whole frame with a good fcs; preamble nibbles 0 and 1 get replaced on the line
   task automatic frame(input logic [15:0] lt, input int n_pay);
      int n, d, total;
      logic [3:0]  v;
      logic [31:0] crc;
      total = 52 + n_pay;
      crc = fe_pkg::CRC_INIT;
      wait_permit(n);
      check(n < 2000, 1);
      {n_short, n_col, n_crs, n_rx} = 128'h0;
      d = n_done;
      for (int i = 0; i <= total; i++)
      begin
         wait_stb();
         if (i < 15)
            v = fe_pkg::NIB_PRE;
         else if (i == 15)
            v = fe_pkg::NIB_SFD;
         else if (i >= 40 && i < 44)
            v = lt[4 * (i[1:0] ^ 2'h2) +: 4];
         else if (i >= total - 8 && i < total)
            v = ~crc[4 * (i - total + 8) +: 4];
         else
            v = i[3:0];
         if (i >= 16 && i < total - 8)
            for (int b = 0; b < 4; b++)
               crc = (crc >> 1) ^ ((crc[0] ^ v[b]) ? fe_pkg::CRC_POLY : 32'h0);
         tx.en <= (i < total);
         tx.data <= v;
      end
      n = 0;
      while (n_done == d && n < 400)
      begin
         @(negedge clk);
         n++;
      end
      check(rx_last, 4'(~crc[31:28]));
   endtask : frame

   task automatic test_idle;
      int moves;
      fe_pkg::mlt3_t prev;
      moves = 0;
      prev = line;
      repeat (200)
      begin
         @(negedge clk);
         moves += (line != prev);
         prev = line;
      end
      check(moves > 20, 1);
      check(n_rx, 0);
      $display("idle test done");
   endtask : test_idle

   task automatic test_frames;
      logic [15:0] lts [3] = '{16'h05dc, 16'h05dd, 16'h0800};
      int n;
      loopback = 1'b1;
      full_duplex = 1'b1;
      repeat (100) @(negedge clk);
      foreach (lts[j])
      begin
         frame(lts[j], 128);
         check(stat.is_type, lts[j] > fe_pkg::LEN_MAX);
         check({stat.crc_err, stat.pre_err, stat.runt}, 0);
         check(n_rx > 0 && n_crs > 0, 1);
      end
      wait_permit(n);
      check((cyc - crs_at) inside {[95:101]}, 1);
      $display("frame test done");
   endtask : test_frames

   // 92 payload nibbles is exactly the minimum data field
   task automatic test_pad;
      for (int p = 0; p < 4; p++)
      begin
         pad_disable = p[1];
         frame(16'h0800, 90 + 2 * p[0]);
         check(n_short, p == 0);
         check(stat.runt, !p[0]);
      end
      pad_disable = 1'b0;
      $display("pad test done");
   endtask : test_pad

   task automatic test_col;
      loopback = 1'b0;
      repeat (100) @(negedge clk);
      for (int d = 0; d < 2; d++)
      begin
         full_duplex = d[0];
         frame(16'h0800, 128);
         check(n_col > 0, !d[0]);
         check(n_crs > 0, 1);
      end
      $display("collision test done");
   endtask : test_col

   task automatic test_10m;
      speed10 = 1'b1;
      full_duplex = 1'b0;
      {n_col, n_man} = 64'h0;
      tx.en <= 1'b1;
      repeat (350) @(negedge clk);
      check(jabber, 1);
      check(n_col > 0 && n_man > 0, 1);
      check(line, 0);
      tx.en <= 1'b0;
      $display("10m test done");
   endtask : test_10m

   initial
   begin
      rst = 1'b1;
      tx = 5'h0;
      {pad_disable, full_duplex, loopback, speed10, rx_line_man} = 5'h0;
      repeat (10) @(negedge clk);
      rst = 1'b0;
      test_idle();
      test_frames();
      test_pad();
      test_col();
      test_10m();
      final_report();
   end

   initial
   begin
      #1000000;
      num_errors++;
      final_report();
   end
endmodule : fast_ethernet_mac_pcs_bench
`default_nettype wire
